/* hdl/itd_drain.v */
// Purpose: translation cache fill and non-committed request draining
// Assumes: register port with one-cycle read data; memory acks per tag
// Notes: request tracker holds eight entries
//
// Functional notes
// [R1] never cache entries whose present flag clear
// [R2] never cache entries whose accessed flag clear
// [R3] stale or new entry value both acceptable
// [R4] cached entries kept until explicitly invalidated; code also clears all entries when a translation enable or disable drain starts
// [R5] upper-level fill allowed without valid leaf
// [R6] cached hit need not re-set accessed/dirty
// [R7] capability register advertises drain support
// [R8] write drained when globally visible ack
// [R9] read drained when all data returned
// [R10] only memory-targeted requests are drained
// [R11] only untranslated address type drained
// [R12] endpoint settles translated reads before completion
// [R13] ats completion handled after prior posted
// [R14] drain before setting translation enabled status
// [R15] optional drain when remapping disabled
// [R16] register invalidate drains before busy clears
// [R17] queued drain finishes before next wait
// [R18] global invalidate drains every request
// [R19] domain invalidate drains matching domain only
// [R20] page invalidate drains domain and overlap
// [R21] pasid-based invalidate always drains both
// [R22] requests tagged with domain and address
`timescale 1ns/1ps
`include "itd_drain_regs.vh"
module itd_drain
(
	input wire clk_i,
	input wire rst_n_i,
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	input wire req_valid_i,
	input wire req_write_i,
	input wire req_mem_i,
	input wire [1:0] req_at_i,
	input wire [15:0] req_domain_i,
	input wire [35:0] req_page_i,
	output reg req_ready_o,
	output reg [2:0] req_tag_o,
	input wire done_valid_i,
	input wire [2:0] done_tag_i,
	input wire done_last_i,
	input wire fill_valid_i,
	input wire fill_present_i,
	input wire fill_accessed_i,
	input wire fill_leaf_i,
	input wire [3:0] fill_idx_i,
	input wire [47:0] fill_data_i,
	input wire [3:0] lookup_idx_i,
	output reg [47:0] lookup_data_o,
	output reg lookup_hit_o,
	input wire ats_cpl_valid_i,
	input wire posted_ahead_i,
	output reg ats_cpl_taken_o,
	output reg translation_enabled_status_o
);
	localparam ST_IDLE = 3'b001;
	localparam ST_DRAIN = 3'b010;
	localparam ST_DONE = 3'b100;
	parameter DRAIN_SUPPORTED = 1'b1;

	reg [`ITD_DEPTH-1:0] pend_reg;
	reg [`ITD_DEPTH-1:0] pend_wr_reg;
	reg [15:0] dom_reg [0:`ITD_DEPTH-1];
	reg [35:0] page_reg [0:`ITD_DEPTH-1];
	reg [`ITD_DEPTH-1:0] watch_reg;
	reg [`ITD_DEPTH-1:0] watch_next;
	reg [2:0] state_reg;
	reg [2:0] src_reg;
	reg en_cmd_reg;
	reg dis_drain_reg;
	reg tes_reg;
	reg inv_busy_reg;
	reg inv_dr_reg;
	reg inv_dw_reg;
	reg [1:0] inv_gran_reg;
	reg [5:0] inv_mask_reg;
	reg [15:0] inv_dom_reg;
	reg [35:0] inv_page_reg;
	reg q_busy_reg;
	reg q_wait_done_reg;
	reg ats_prev_reg;
	reg ats_pend_reg;
	reg [2:0] free_idx;
	reg free_any;
	reg [35:0] amask;
	reg sel_dr;
	reg sel_dw;
	reg [1:0] sel_gran;
	reg start;
	integer i;
	wire ats_sync;
	wire [47:0] mem_rdata;
	wire mem_rvalid;
	wire fill_ok;
	wire track;
	wire take;

	itd_sync3 u_ats_sync
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i(ats_cpl_valid_i),
		.q_o(ats_sync)
	);

	// fills with clear present or accessed flag are dropped; upper levels allowed
	assign fill_ok = fill_valid_i & fill_present_i & fill_accessed_i; // [R1] [R2] [R5]

	itd_tlb_mem u_tlb
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.wr_i(fill_ok),
		.wr_idx_i(fill_idx_i),
		.wr_data_i(fill_data_i),
		.clr_all_i(start & (sel_gran == `ITD_GRAN_GLOBAL)),
		.rd_idx_i(lookup_idx_i),
		.rd_data_o(mem_rdata),
		.rd_valid_o(mem_rvalid)
	);

	// hits return the cached copy with no flag write-back and no ageing
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			lookup_data_o <= 48'h0;
			lookup_hit_o <= 1'b0;
		end
		else
		begin
			lookup_data_o <= mem_rdata; // [R3] [R4] [R6]
			lookup_hit_o <= mem_rvalid;
		end
	end

	always @*
	begin
		free_idx = 3'h0;
		free_any = 1'b0;
		for (i = `ITD_DEPTH - 1; i >= 0; i = i - 1)
		begin
			if (!pend_reg[i])
			begin
				free_idx = i[2:0];
				free_any = 1'b1;
			end
		end
	end

	assign track = req_mem_i & (req_at_i == `ITD_AT_UNTRANSLATED); // [R10] [R11]
	assign take = req_valid_i & req_ready_o;

	// command decode from either submission path
	always @*
	begin
		sel_dr = 1'b0;
		sel_dw = 1'b0;
		sel_gran = `ITD_GRAN_GLOBAL;
		start = 1'b0;
		if (state_reg == ST_IDLE)
		begin
			if (en_cmd_reg && !tes_reg)
			begin
				start = 1'b1;
				sel_dr = 1'b1;
				sel_dw = 1'b1; // [R14]
			end
			else if (!en_cmd_reg && tes_reg && dis_drain_reg)
			begin
				start = 1'b1;
				sel_dr = 1'b1;
				sel_dw = 1'b1; // [R15]
			end
			else if (inv_busy_reg)
			begin
				start = 1'b1;
				sel_dr = inv_dr_reg;
				sel_dw = inv_dw_reg;
				sel_gran = inv_gran_reg;
			end
			else if (q_busy_reg)
			begin
				start = 1'b1;
				sel_dr = inv_dr_reg;
				sel_dw = inv_dw_reg;
				sel_gran = inv_gran_reg;
			end
		end
	end

	always @*
	begin
		amask = ~36'h0 << inv_mask_reg;
		for (i = 0; i < `ITD_DEPTH; i = i + 1)
		begin
			case (sel_gran)
			`ITD_GRAN_DOMAIN:
				watch_next[i] = pend_reg[i] & (dom_reg[i] == inv_dom_reg); // [R19]
			`ITD_GRAN_PAGE:
				watch_next[i] = pend_reg[i] & (dom_reg[i] == inv_dom_reg) &
					((page_reg[i] & amask) == (inv_page_reg & amask)); // [R20]
			default:
				watch_next[i] = pend_reg[i]; // [R18]
			endcase
			watch_next[i] = watch_next[i] & (pend_wr_reg[i] ? sel_dw : sel_dr);
		end
	end

	// tracker of non-committed requests, tagged for selective drains
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pend_reg <= {`ITD_DEPTH{1'b0}};
			pend_wr_reg <= {`ITD_DEPTH{1'b0}};
			req_ready_o <= 1'b0;
			req_tag_o <= 3'h0;
		end
		else
		begin
			if (done_valid_i && (done_last_i || pend_wr_reg[done_tag_i]))
				pend_reg[done_tag_i] <= 1'b0; // [R8] [R9]
			// slot named by the tag already shown, so tracker and far side agree
			if (take && track)
			begin
				pend_reg[req_tag_o] <= 1'b1;
				pend_wr_reg[req_tag_o] <= req_write_i;
				dom_reg[req_tag_o] <= req_domain_i; // [R22]
				page_reg[req_tag_o] <= req_page_i;
			end
			req_tag_o <= free_idx;
			req_ready_o <= free_any & ~(take & track);
		end
	end

	// drain sequencer
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_reg <= ST_IDLE;
			watch_reg <= {`ITD_DEPTH{1'b0}};
			src_reg <= 3'h0;
			tes_reg <= 1'b0;
			translation_enabled_status_o <= 1'b0;
			q_wait_done_reg <= 1'b0;
		end
		else
		begin
			translation_enabled_status_o <= tes_reg;
			case (state_reg)
			ST_IDLE:
			begin
				if (start)
				begin
					watch_reg <= watch_next;
					src_reg <= {inv_busy_reg & ~(en_cmd_reg ^ tes_reg), en_cmd_reg & ~tes_reg,
						~en_cmd_reg & tes_reg};
					state_reg <= ST_DRAIN;
				end
				q_wait_done_reg <= 1'b0;
			end
			ST_DRAIN:
			begin
				watch_reg <= watch_reg & pend_reg;
				if ((watch_reg & pend_reg) == {`ITD_DEPTH{1'b0}})
					state_reg <= ST_DONE;
			end
			ST_DONE:
			begin
				if (src_reg[1])
					tes_reg <= 1'b1; // [R14]
				else if (src_reg[0])
					tes_reg <= 1'b0;
				else if (!src_reg[2])
					q_wait_done_reg <= 1'b1; // [R17] [R21]
				state_reg <= ST_IDLE;
			end
			default:
				state_reg <= ST_IDLE;
			endcase
			if (!en_cmd_reg && !dis_drain_reg && state_reg == ST_IDLE)
				tes_reg <= 1'b0;
		end
	end

	// ats completion waits for posted traffic ahead of it
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ats_prev_reg <= 1'b0;
			ats_pend_reg <= 1'b0;
			ats_cpl_taken_o <= 1'b0;
		end
		else
		begin
			// one completion per rising edge of the message line
			ats_prev_reg <= ats_sync;
			if (ats_sync && !ats_prev_reg)
				ats_pend_reg <= 1'b1;
			else if (ats_pend_reg && !posted_ahead_i)
				ats_pend_reg <= 1'b0;
			ats_cpl_taken_o <= ats_pend_reg & ~posted_ahead_i; // [R12] [R13]
		end
	end

	// register port
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			en_cmd_reg <= 1'b0;
			dis_drain_reg <= 1'b0;
			inv_busy_reg <= 1'b0;
			inv_dr_reg <= 1'b0;
			inv_dw_reg <= 1'b0;
			inv_gran_reg <= `ITD_GRAN_GLOBAL;
			inv_mask_reg <= 6'h0;
			inv_dom_reg <= 16'h0;
			inv_page_reg <= 36'h0;
			q_busy_reg <= 1'b0;
			reg_rdata_o <= 32'h0;
		end
		else
		begin
			if (state_reg == ST_DONE && src_reg[2])
				inv_busy_reg <= 1'b0; // [R16]
			if (state_reg == ST_DONE && !src_reg[2] && !src_reg[1] && !src_reg[0])
				q_busy_reg <= 1'b0;
			if (reg_wr_i)
			begin
				case (reg_addr_i)
				`ITD_OFF_GCMD:
				begin
					en_cmd_reg <= reg_wdata_i[`ITD_GCMD_EN_BIT];
					dis_drain_reg <= reg_wdata_i[`ITD_GCMD_DIS_DRAIN_BIT];
				end
				`ITD_OFF_INV:
				begin
					if (!inv_busy_reg && !q_busy_reg && reg_wdata_i[`ITD_INV_BUSY_BIT])
					begin
						inv_busy_reg <= 1'b1;
						inv_dr_reg <= reg_wdata_i[`ITD_INV_DR_BIT];
						inv_dw_reg <= reg_wdata_i[`ITD_INV_DW_BIT];
						inv_gran_reg <= reg_wdata_i[`ITD_INV_GRAN_LSB+1:`ITD_INV_GRAN_LSB];
						inv_mask_reg <= reg_wdata_i[`ITD_INV_MASK_LSB+5:`ITD_INV_MASK_LSB];
						inv_dom_reg <= reg_wdata_i[15:0];
					end
				end
				`ITD_OFF_INV_ADDR:
					inv_page_reg <= {4'h0, reg_wdata_i};
				`ITD_OFF_QCMD:
				begin
					if (!inv_busy_reg && !q_busy_reg && reg_wdata_i[`ITD_QCMD_WAIT_BIT])
					begin
						q_busy_reg <= 1'b1;
						inv_dr_reg <= reg_wdata_i[`ITD_INV_DR_BIT] | reg_wdata_i[`ITD_QCMD_PASID_BIT];
						inv_dw_reg <= reg_wdata_i[`ITD_INV_DW_BIT] | reg_wdata_i[`ITD_QCMD_PASID_BIT]; // [R21]
						inv_gran_reg <= reg_wdata_i[`ITD_INV_GRAN_LSB+1:`ITD_INV_GRAN_LSB];
						inv_mask_reg <= reg_wdata_i[`ITD_INV_MASK_LSB+5:`ITD_INV_MASK_LSB];
						inv_dom_reg <= reg_wdata_i[15:0];
					end
				end
				default:
					dis_drain_reg <= dis_drain_reg;
				endcase
			end
			if (reg_rd_i)
			begin
				case (reg_addr_i)
				`ITD_OFF_CAP:
					reg_rdata_o <= {31'h0, DRAIN_SUPPORTED}; // [R7]
				`ITD_OFF_GCMD:
					reg_rdata_o <= {30'h0, dis_drain_reg, en_cmd_reg};
				`ITD_OFF_GSTS:
					reg_rdata_o <= {31'h0, tes_reg};
				`ITD_OFF_INV:
					reg_rdata_o <= {inv_busy_reg, inv_dr_reg, inv_dw_reg, inv_gran_reg, 5'h0,
						inv_mask_reg, inv_dom_reg};
				`ITD_OFF_INV_ADDR:
					reg_rdata_o <= inv_page_reg[31:0];
				`ITD_OFF_QSTS:
					reg_rdata_o <= {q_busy_reg, q_wait_done_reg, 30'h0};
				`ITD_OFF_PEND:
					reg_rdata_o <= {24'h0, pend_reg};
				default:
					reg_rdata_o <= 32'h0;
				endcase
			end
			else
				reg_rdata_o <= 32'h0;
		end
	end
endmodule

/* hdl/itd_drain_regs.vh */
// Purpose: constants for the translation cache and request drain block
// Assumes: 40 MHz clock, 32-bit register port
// Notes: offsets are byte addresses of aligned words
`ifndef ITD_DRAIN_REGS_VH
`define ITD_DRAIN_REGS_VH
`define ITD_OFF_CAP 8'h00
`define ITD_OFF_GCMD 8'h04
`define ITD_OFF_GSTS 8'h08
`define ITD_OFF_INV 8'h0C
`define ITD_OFF_INV_ADDR 8'h10
`define ITD_OFF_QCMD 8'h14
`define ITD_OFF_QSTS 8'h18
`define ITD_OFF_PEND 8'h1C
`define ITD_CAP_DRAIN_BIT 0
`define ITD_GCMD_EN_BIT 0
`define ITD_GCMD_DIS_DRAIN_BIT 1
`define ITD_INV_BUSY_BIT 31
`define ITD_INV_DR_BIT 30
`define ITD_INV_DW_BIT 29
`define ITD_INV_GRAN_LSB 27
`define ITD_INV_MASK_LSB 16
`define ITD_QCMD_WAIT_BIT 31
`define ITD_QCMD_PASID_BIT 30
`define ITD_GRAN_GLOBAL 2'h1
`define ITD_GRAN_DOMAIN 2'h2
`define ITD_GRAN_PAGE 2'h3
`define ITD_AT_UNTRANSLATED 2'h0
`define ITD_AT_TRANSLATED 2'h2
`define ITD_PAGE_SHIFT 12
`define ITD_DEPTH 8
`define ITD_TLB_DEPTH 16
`endif

/* hdl/itd_sync3.v */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: single clock domain clk_i
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
module itd_sync3
(
	input wire clk_i,
	input wire rst_n_i,
	input wire d_i,
	output reg q_o
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			q_o <= 1'b0;
		end
		else
		begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				q_o <= s3_reg;
		end
	end
endmodule

/* hdl/itd_tlb_mem.v */
// Purpose: small translation cache storage
// Assumes: one write and one registered read per cycle
// Notes: entries are never aged out
`timescale 1ns/1ps
`include "itd_drain_regs.vh"
module itd_tlb_mem
(
	input wire clk_i,
	input wire rst_n_i,
	input wire wr_i,
	input wire [3:0] wr_idx_i,
	input wire [47:0] wr_data_i,
	input wire clr_all_i,
	input wire [3:0] rd_idx_i,
	output reg [47:0] rd_data_o,
	output reg rd_valid_o
);
	reg [47:0] mem [0:`ITD_TLB_DEPTH-1];
	reg [`ITD_TLB_DEPTH-1:0] valid_reg;
	always @(posedge clk_i)
	begin
		if (wr_i)
			mem[wr_idx_i] <= wr_data_i;
		rd_data_o <= mem[rd_idx_i];
	end
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			valid_reg <= {`ITD_TLB_DEPTH{1'b0}};
			rd_valid_o <= 1'b0;
		end
		else
		begin
			if (clr_all_i)
				valid_reg <= {`ITD_TLB_DEPTH{1'b0}};
			else if (wr_i)
				valid_reg[wr_idx_i] <= 1'b1;
			rd_valid_o <= valid_reg[rd_idx_i] & ~(clr_all_i | (wr_i && wr_idx_i == rd_idx_i));
		end
	end
endmodule

/* bench/itd_drain_monitor.sv */
// Purpose: port checks for the drain and cache block
// Assumes: one clock, sync reset
// Notes: tracks tags of drainable requests
`timescale 1ns/1ps
`include "itd_drain_regs.vh"
module itd_drain_monitor
#(
	parameter DRAIN_SUPPORTED = 1'b1
)
(
	input wire clk_i,
	input wire rst_n_i,
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [31:0] reg_rdata_o,
	input wire req_valid_i,
	input wire req_mem_i,
	input wire [1:0] req_at_i,
	input wire req_ready_o,
	input wire [2:0] req_tag_o,
	input wire done_valid_i,
	input wire [2:0] done_tag_i,
	input wire done_last_i,
	input wire fill_valid_i,
	input wire fill_present_i,
	input wire fill_accessed_i,
	input wire [3:0] fill_idx_i,
	input wire [3:0] lookup_idx_i,
	input wire lookup_hit_o,
	input wire posted_ahead_i,
	input wire ats_cpl_taken_o,
	input wire translation_enabled_status_o
);
	logic [7:0] dr, dm, sn_e, sn_i, sn_q;
	logic [15:0] vm;
	logic wi;
	assign dm = (done_valid_i & done_last_i) ? 8'h01 << done_tag_i : 8'h00;
	assign wi = reg_wr_i && reg_addr_i == `ITD_OFF_INV && reg_wdata_i[31:29] == 3'h7;
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			dr <= 8'h00;
			sn_e <= 8'h00;
			sn_i <= 8'h00;
			sn_q <= 8'h00;
			vm <= 16'h0000;
		end
		else
		begin
			dr <= (dr | ((req_valid_i & req_ready_o & req_mem_i & req_at_i == 2'h0) ? 8'h01 << req_tag_o : 8'h00)) & ~dm;
			sn_e <= (reg_wr_i && reg_addr_i == `ITD_OFF_GCMD && reg_wdata_i[0]) ? dr & ~dm : sn_e & ~dm;
			sn_i <= (wi && reg_wdata_i[28:27] == `ITD_GRAN_GLOBAL) ? dr & ~dm : sn_i & ~dm;
			sn_q <= (reg_wr_i && reg_addr_i == `ITD_OFF_QCMD && reg_wdata_i[31:30] == 2'h3) ? dr & ~dm : sn_q & ~dm;
			if (fill_valid_i)
				vm[fill_idx_i] <= vm[fill_idx_i] | (fill_present_i & fill_accessed_i);
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_cap;
		reg_rd_i && reg_addr_i == `ITD_OFF_CAP |=> reg_rdata_o[0] == DRAIN_SUPPORTED;
	endproperty
	a_cap: assert property (p_cap) else $error("drain capability bit wrong");
	property p_rdz;
		!reg_rd_i |=> reg_rdata_o == 32'h0000_0000;
	endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside read slot");
	property p_tes;
		$rose(translation_enabled_status_o) |-> sn_e == 8'h00;
	endproperty
	a_tes: assert property (p_tes) else $error("enabled before drain");
	property p_off;
		reg_wr_i && reg_addr_i == `ITD_OFF_GCMD && reg_wdata_i[1:0] == 2'h0 |-> ##[1:4] !translation_enabled_status_o;
	endproperty
	a_off: assert property (p_off) else $error("enabled status kept after disable");
	property p_inv;
		reg_rd_i && reg_addr_i == `ITD_OFF_INV && sn_i != 8'h00 |=> reg_rdata_o[31];
	endproperty
	a_inv: assert property (p_inv) else $error("busy cleared before drain");
	property p_q;
		reg_rd_i && reg_addr_i == `ITD_OFF_QSTS && sn_q != 8'h00 |=> reg_rdata_o[31];
	endproperty
	a_q: assert property (p_q) else $error("queue wait done before drain");
	property p_ats;
		ats_cpl_taken_o |-> !$past(posted_ahead_i);
	endproperty
	a_ats: assert property (p_ats) else $error("completion passed posted traffic");
	property p_fill;
		lookup_hit_o |-> vm[$past(lookup_idx_i, 2)];
	endproperty
	a_fill: assert property (p_fill) else $error("hit on entry never filled validly");
endmodule
bind itd_drain itd_drain_monitor #(.DRAIN_SUPPORTED(DRAIN_SUPPORTED)) u_mon (.*);

/* bench/itd_mem_model.sv */
// Purpose: memory ordering point model
// Assumes: acks in request order
// Notes: stall holds every request pending
`timescale 1ns/1ps
module itd_mem_model
(
	input wire clk_i,
	input wire rst_n_i,
	input wire acc_i,
	input wire wr_i,
	input wire [2:0] tag_i,
	input wire stall_i,
	output reg done_valid_o,
	output reg [2:0] done_tag_o,
	output reg done_last_o
);
	logic [3:0] q[$];
	logic beat;
	always @(posedge clk_i)
	begin
		if (acc_i)
			q.push_back({wr_i, tag_i});
		done_valid_o <= 1'b0;
		done_tag_o <= ~done_tag_o;
		done_last_o <= ~done_last_o;
		if (!rst_n_i)
		begin
			q.delete();
			beat <= 1'b0;
			done_tag_o <= 3'h0;
			done_last_o <= 1'b0;
		end
		else if (!stall_i && q.size() > 0)
		begin
			done_valid_o <= 1'b1;
			done_tag_o <= q[0][2:0];
			done_last_o <= q[0][3] | beat;
			beat <= ~(q[0][3] | beat);
			if (q[0][3] | beat)
				void'(q.pop_front());
		end
	end
endmodule

/* bench/tb_top.sv */
// Purpose: bench for the drain and cache block
// Assumes: 40 MHz clock
// Notes: stalls the memory model to hold requests
`timescale 1ns/1ps
`include "itd_drain_regs.vh"
module tb_top;
	logic clk_i = 1'b0;
	logic rst_n_i, reg_wr_i, reg_rd_i, req_valid_i, req_write_i, req_mem_i, req_ready_o, stall;
	logic fill_valid_i, fill_present_i, fill_accessed_i, fill_leaf_i, ats_cpl_valid_i, posted_ahead_i;
	logic done_valid_i, done_last_i, lookup_hit_o, ats_cpl_taken_o, translation_enabled_status_o;
	logic [1:0] req_at_i;
	logic [2:0] req_tag_o, done_tag_i;
	logic [3:0] fill_idx_i, lookup_idx_i;
	logic [7:0] reg_addr_i;
	logic [15:0] req_domain_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, d;
	logic [35:0] req_page_i;
	logic [47:0] fill_data_i, lookup_data_o;
	int mismatches = 0;
	int samples_checked = 0;
	int taken_n = 0;
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i)
		taken_n += (ats_cpl_taken_o === 1'b1);
	itd_drain uut (.*);
	itd_mem_model mem (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.acc_i(req_valid_i & req_ready_o & req_mem_i & (req_at_i == `ITD_AT_UNTRANSLATED)),
		.wr_i(req_write_i), .tag_i(req_tag_o), .stall_i(stall), .done_valid_o(done_valid_i),
		.done_tag_o(done_tag_i), .done_last_o(done_last_i));
	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string n, input logic [47:0] e, input logic [47:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask
	task poll(input logic [7:0] a, input int b, input logic v);
		int n;
		for (n = 0; n < 100; n++)
		begin
			rd(a);
			if (d[b] === v)
				break;
		end
		if (n == 100)
		begin
			chk("poll", v, ~v);
			final_report();
		end
	endtask
	task req(input logic w, input logic m, input logic [1:0] t);
		int n;
		@(posedge clk_i);
		req_valid_i <= 1'b1;
		req_write_i <= w;
		req_mem_i <= m;
		req_at_i <= t;
		for (n = 0; n < 50; n++)
		begin
			#1;
			if (req_ready_o === 1'b1)
				break;
			@(posedge clk_i);
		end
		@(posedge clk_i);
		req_valid_i <= 1'b0;
		if (n == 50)
		begin
			chk("ready", 1'b1, 1'b0);
			final_report();
		end
	endtask
	task fill(input logic [3:0] i, input logic p, input logic ac, input logic [47:0] v);
		@(posedge clk_i);
		fill_valid_i <= 1'b1;
		fill_idx_i <= i;
		fill_present_i <= p;
		fill_accessed_i <= ac;
		fill_data_i <= v;
		@(posedge clk_i);
		fill_valid_i <= 1'b0;
	endtask
	task look(input logic [3:0] i);
		@(posedge clk_i);
		lookup_idx_i <= i;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	initial
	begin
		int n;
		rst_n_i = 1'b0;
		{reg_wr_i, reg_rd_i, req_valid_i, req_write_i, req_mem_i, fill_valid_i, fill_present_i} = '0;
		{fill_accessed_i, fill_leaf_i, ats_cpl_valid_i, posted_ahead_i, stall, req_at_i} = '0;
		{fill_idx_i, lookup_idx_i, reg_addr_i, reg_wdata_i, req_domain_i, req_page_i, fill_data_i} = '0;
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rd(`ITD_OFF_CAP);
		chk("cap_drain", 1'b1, d[0]);
		rd(8'h20);
		chk("unmapped", 32'h0, d);
		stall <= 1'b1;
		req(1'b0, 1'b1, `ITD_AT_UNTRANSLATED);
		wr(`ITD_OFF_GCMD, 32'h0000_0001);
		repeat (8) @(posedge clk_i);
		rd(`ITD_OFF_GSTS);
		chk("tes_early", 1'b0, d[0]);
		stall <= 1'b0;
		poll(`ITD_OFF_GSTS, 0, 1'b1);
		@(posedge clk_i);
		#1;
		chk("tes_pin", 1'b1, translation_enabled_status_o);
		stall <= 1'b1;
		req(1'b1, 1'b1, `ITD_AT_UNTRANSLATED);
		wr(`ITD_OFF_INV, 32'hE800_0000);
		rd(`ITD_OFF_INV);
		chk("inv_busy", 1'b1, d[31]);
		stall <= 1'b0;
		poll(`ITD_OFF_INV, 31, 1'b0);
		stall <= 1'b1;
		req(1'b1, 1'b0, `ITD_AT_UNTRANSLATED);
		req(1'b0, 1'b1, `ITD_AT_TRANSLATED);
		wr(`ITD_OFF_INV, 32'hE800_0000);
		poll(`ITD_OFF_INV, 31, 1'b0);
		req(1'b1, 1'b1, `ITD_AT_UNTRANSLATED);
		wr(`ITD_OFF_QCMD, 32'hC000_0000);
		rd(`ITD_OFF_QSTS);
		chk("queue_busy", 1'b1, d[31]);
		stall <= 1'b0;
		poll(`ITD_OFF_QSTS, 31, 1'b0);
		fill(4'h1, 1'b0, 1'b1, 48'h1111_2222_3333);
		fill(4'h2, 1'b1, 1'b0, 48'h4444_5555_6666);
		fill(4'h3, 1'b1, 1'b1, 48'hA5A5_0000_1234);
		look(4'h1);
		chk("hit_absent", 1'b0, lookup_hit_o);
		look(4'h2);
		chk("hit_unaccessed", 1'b0, lookup_hit_o);
		repeat (500) @(posedge clk_i);
		look(4'h3);
		chk("hit_kept", 1'b1, lookup_hit_o);
		chk("data_kept", 48'hA5A5_0000_1234, lookup_data_o);
		@(posedge clk_i);
		posted_ahead_i <= 1'b1;
		ats_cpl_valid_i <= 1'b1;
		n = taken_n;
		repeat (20) @(posedge clk_i);
		#1;
		chk("ats_early", n, taken_n);
		@(posedge clk_i);
		posted_ahead_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		#1;
		chk("ats_taken", n + 1, taken_n);
		ats_cpl_valid_i <= 1'b0;
		wr(`ITD_OFF_GCMD, 32'h0000_0000);
		repeat (3) @(posedge clk_i);
		#1;
		chk("tes_off", 1'b0, translation_enabled_status_o);
		final_report();
	end
endmodule
